// *** verilog/dssf_pkg.sv ***
// Constants for the device status and supply fault logic.
// Assumes a single 20 MHz clock and a synchronous, active-high reset.
package dssf_pkg;

  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned CLK_PERIOD_NS   = 50;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SUMMARY_OFS      = 8'h01;
  localparam logic [7:0] SUPPLY_OFS       = 8'h02;

  // ----------------------------------------------------------------
  // Summary status field positions
  // ----------------------------------------------------------------
  localparam int SUM_CHAN_A_BIT           = 7;
  localparam int SUM_CHAN_B_BIT           = 6;
  localparam int SUM_LINK_BIT             = 5;
  localparam int SUM_MEMTHERM_BIT         = 4;
  localparam int SUM_SUPPLY_BIT           = 3;
  localparam int SUM_TEST_BIT             = 2;
  localparam int SUM_RESET_BIT            = 1;
  localparam int SUM_INIT_BIT             = 0;

  // ----------------------------------------------------------------
  // Supply fault status field positions (bit 4 reserved)
  // ----------------------------------------------------------------
  localparam int SUP_BUF_UV_BIT           = 7;
  localparam int SUP_BUS_UV_BIT           = 6;
  localparam int SUP_BUF_OV_BIT           = 5;
  localparam int SUP_AREG_BIT             = 3;
  localparam int SUP_DREG_BIT             = 2;
  localparam int SUP_OTPREG_BIT           = 1;
  localparam int SUP_CONT_BIT             = 0;
  localparam logic [7:0] SUP_USED_MASK    = 8'hEF;

  // ----------------------------------------------------------------
  // Reset values (undefined bits taken as zero)
  // ----------------------------------------------------------------
  localparam logic [7:0] SUMMARY_RST      = 8'hC3;
  localparam logic [7:0] SUPPLY_RST       = 8'h00;
  localparam logic [7:0] RD_DATA_RST      = 8'h00;
  localparam logic [15:0] TIMER_RST       = 16'h0000;

  // ----------------------------------------------------------------
  // Protocol selection codes
  // ----------------------------------------------------------------
  localparam logic [2:0] PROTO_DSI3_A     = 3'h0;
  localparam logic [2:0] PROTO_PSI5_A     = 3'h1;
  localparam logic [2:0] PROTO_DSI3_B     = 3'h2;
  localparam logic [2:0] PROTO_SPI_A      = 3'h3;
  localparam logic [2:0] PROTO_SPI_B      = 3'h4;
  localparam logic [2:0] PROTO_PSI5_B     = 3'h5;
  localparam logic [2:0] PROTO_I2C_A      = 3'h6;
  localparam logic [2:0] PROTO_I2C_B      = 3'h7;

  // ----------------------------------------------------------------
  // Defaults for the timing parameters of the top module
  // ----------------------------------------------------------------
  localparam int unsigned TICK_CYCLES_DEF   = 2000;
  localparam int unsigned RECOVERY_TICKS_DEF = 16;
  localparam int unsigned DATA_VALID_CYCLES_DEF = 20000;

endpackage

// *** verilog/dssf_status.sv ***
// Device status and supply fault logic: summary flags, supply fault latch,
// common recovery timer, response gating, reset/init/test indicators.
// Assumes register reads and status transmissions arrive as one-cycle strobes
// from same-clock protocol logic; supply monitors are asynchronous pins.
`timescale 1ns/1ps

module dssf_status #(
  parameter int unsigned TICK_CYCLES       = dssf_pkg::TICK_CYCLES_DEF,
  parameter int unsigned RECOVERY_TICKS    = dssf_pkg::RECOVERY_TICKS_DEF,
  parameter int unsigned DATA_VALID_CYCLES = dssf_pkg::DATA_VALID_CYCLES_DEF
) (
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  // Register read port
  input  wire logic       RD_STB,
  input  wire logic [7:0] RD_ADDR,
  output logic      [7:0] RD_DATA,
  // Status transmission and response handshake
  input  wire logic       STAT_TX_STB,
  input  wire logic       RESP_DONE,
  output logic            RESP_SUPPRESS,
  output logic            ERR_CODE_SEND,
  // Configuration
  input  wire logic [2:0] PROTOCOL_SELECT,
  input  wire logic       SUPPLY_CLEAR_POLICY,
  input  wire logic [7:0] CHAN_A_USER_CONFIG_ONE,
  input  wire logic [7:0] CHAN_B_USER_CONFIG_ONE,
  input  wire logic [7:0] CHAN_A_USER_CONFIG_THREE,
  input  wire logic [7:0] CHAN_B_USER_CONFIG_THREE,
  // Channel status
  input  wire logic [3:0] CHAN_A_STATUS_REG,
  input  wire logic [3:0] CHAN_B_STATUS_REG,
  // Link and memory/thermal sources
  input  wire logic       OUTPUT_MISMATCH_FAULT,
  input  wire logic       OSC_TRAINING_FAULT,
  input  wire logic       FACTORY_MEM_FAULT,
  input  wire logic       USER_MEM_FAULT,
  input  wire logic       USER_ARRAY_FAULT,
  input  wire logic       USER_PROG_BUSY,
  input  wire logic       CHAN_A_THERMAL_FAULT,
  input  wire logic       CHAN_B_THERMAL_FAULT,
  // Test mode operations
  input  wire logic       TEST_ENTER,
  input  wire logic       TEST_EXIT,
  // Asynchronous supply monitors
  input  wire logic       BUFFER_UNDERVOLTAGE,
  input  wire logic       BUS_INPUT_UNDERVOLTAGE,
  input  wire logic       BUFFER_OVERVOLTAGE,
  input  wire logic       ANALOG_REGULATOR_FAULT,
  input  wire logic       DIGITAL_REGULATOR_FAULT,
  input  wire logic       OTP_REGULATOR_FAULT,
  input  wire logic       PERIMETER_CONTINUITY_FAULT,
  // Status views
  output logic      [7:0] SUMMARY_STATUS,
  output logic      [7:0] SUPPLY_FAULT_STATUS
);
  import dssf_pkg::*;

  // ----------------------------------------------------------------
  // Protocol decoding
  // ----------------------------------------------------------------
  function automatic logic is_psi5(input logic [2:0] sel);
    is_psi5 = (sel == PROTO_PSI5_A) || (sel == PROTO_PSI5_B);
  endfunction

  function automatic logic is_i2c(input logic [2:0] sel);
    is_i2c = (sel == PROTO_I2C_A) || (sel == PROTO_I2C_B);
  endfunction

  function automatic logic is_dsi_spi(input logic [2:0] sel);
    is_dsi_spi = !is_psi5(sel) && !is_i2c(sel);
  endfunction

  localparam logic [15:0] RECOVERY_LOAD = 16'(RECOVERY_TICKS);
  localparam logic [15:0] TICK_LAST     = 16'(TICK_CYCLES - 1);
  localparam logic [23:0] DV_LAST       = 24'(DATA_VALID_CYCLES - 1);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]  mon_meta_reg;
  logic [7:0]  mon_sync_reg;
  logic [7:0]  mon_raw;
  logic [7:0]  supply_reg;
  logic [7:0]  supply_next;
  logic [15:0] timer_reg;
  logic [15:0] tick_cnt_reg;
  logic        tick;
  logic        fault_raise;
  logic        timer_zero;
  logic        timer_expire;
  logic        mode_dsi;
  logic        mode_auto;
  logic        mode_i2c;
  logic        rd_summary;
  logic        rd_supply;
  logic        supply_clear;
  logic        err_code_reg;
  logic        test_reg;
  logic        reset_seen_reg;
  logic        init_reg;
  logic [23:0] dv_cnt_reg;
  logic        cfg_primed_reg;
  logic [11:0] cfg_prev_reg;
  logic [11:0] cfg_now;
  logic        cfg_changed;
  logic [7:0]  summary_now;
  logic [7:0]  rd_data_reg;
  logic [7:0]  summary_out_reg;
  logic [7:0]  supply_out_reg;
  logic        suppress_reg;

  // ----------------------------------------------------------------
  // Supply monitor synchronisers
  // ----------------------------------------------------------------
  assign mon_raw = {BUFFER_UNDERVOLTAGE, BUS_INPUT_UNDERVOLTAGE, BUFFER_OVERVOLTAGE,
                    1'b0, ANALOG_REGULATOR_FAULT, DIGITAL_REGULATOR_FAULT,
                    OTP_REGULATOR_FAULT, PERIMETER_CONTINUITY_FAULT};

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      mon_meta_reg <= SUPPLY_RST;
      mon_sync_reg <= SUPPLY_RST;
    end else begin
      mon_meta_reg <= mon_raw;
      mon_sync_reg <= mon_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Mode and access decode
  // ----------------------------------------------------------------
  assign mode_auto  = is_psi5(PROTOCOL_SELECT) || SUPPLY_CLEAR_POLICY;
  assign mode_dsi   = is_dsi_spi(PROTOCOL_SELECT) && !SUPPLY_CLEAR_POLICY;
  assign mode_i2c   = is_i2c(PROTOCOL_SELECT) && !SUPPLY_CLEAR_POLICY;
  assign rd_summary = RD_STB && (RD_ADDR == SUMMARY_OFS);
  assign rd_supply  = RD_STB && (RD_ADDR == SUPPLY_OFS);

  // ----------------------------------------------------------------
  // Recovery timer
  // ----------------------------------------------------------------
  // Reload follows the live monitor, not the latched bit; a latched bit that
  // waits for a read would otherwise hold the timer forever.
  assign fault_raise  = |(mon_sync_reg & SUP_USED_MASK);
  assign timer_zero   = (timer_reg == TIMER_RST);
  assign tick         = (tick_cnt_reg == TICK_LAST);
  assign timer_expire = !fault_raise && tick && (timer_reg == 16'h0001);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      tick_cnt_reg <= TIMER_RST;
    end else if (tick) begin
      tick_cnt_reg <= TIMER_RST;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      timer_reg <= TIMER_RST;
    end else if (fault_raise) begin
      timer_reg <= RECOVERY_LOAD;
    end else if (tick && !timer_zero) begin
      timer_reg <= timer_reg - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Supply fault bits
  // ----------------------------------------------------------------
  always_comb begin
    supply_clear = 1'b0;
    if (mode_auto) begin
      supply_clear = timer_zero;
    end else if (mode_dsi) begin
      supply_clear = timer_zero && (rd_supply || STAT_TX_STB);
    end else if (mode_i2c) begin
      supply_clear = timer_zero && rd_supply;
    end
  end

  // A monitor still reporting in the clearing cycle keeps its bit.
  always_comb begin
    supply_next = supply_clear ? SUPPLY_RST : supply_reg;
    supply_next = supply_next | (mon_sync_reg & SUP_USED_MASK);
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      supply_reg <= SUPPLY_RST;
    end else begin
      supply_reg <= supply_next;
    end
  end

  // ----------------------------------------------------------------
  // Response gating
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      suppress_reg <= 1'b0;
    end else begin
      suppress_reg <= fault_raise || !timer_zero;
    end
  end

  // One error-code response owed after each expiry while mode_dsi is set; a new expiry wins
  // over the completion of the previous response.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      err_code_reg <= 1'b0;
    end else if (mode_dsi && timer_expire) begin
      err_code_reg <= 1'b1;
    end else if (!mode_dsi || RESP_DONE) begin
      err_code_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Test, reset and init indicators
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      test_reg <= SUMMARY_RST[SUM_TEST_BIT];
    end else if (TEST_ENTER) begin
      test_reg <= 1'b1;
    end else if (TEST_EXIT) begin
      test_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      reset_seen_reg <= SUMMARY_RST[SUM_RESET_BIT];
    end else if (rd_summary || STAT_TX_STB) begin
      reset_seen_reg <= 1'b0;
    end
  end

  assign cfg_now = {CHAN_A_USER_CONFIG_ONE[7:2], CHAN_B_USER_CONFIG_ONE[7:2]} ^ 12'h000;
  logic [3:0] cfg3_now;
  logic [3:0] cfg3_prev_reg;
  assign cfg3_now = {CHAN_A_USER_CONFIG_THREE[1:0], CHAN_B_USER_CONFIG_THREE[1:0]};
  // Comparison waits one cycle after reset so the captured values are real.
  assign cfg_changed = cfg_primed_reg &&
                       ((cfg_now != cfg_prev_reg) || (cfg3_now != cfg3_prev_reg));

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      cfg_primed_reg <= 1'b0;
      cfg_prev_reg   <= 12'h000;
      cfg3_prev_reg  <= 4'h0;
    end else begin
      cfg_primed_reg <= 1'b1;
      cfg_prev_reg   <= cfg_now;
      cfg3_prev_reg  <= cfg3_now;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      init_reg   <= SUMMARY_RST[SUM_INIT_BIT];
      dv_cnt_reg <= 24'h000000;
    end else if (cfg_changed) begin
      init_reg   <= 1'b1;
      dv_cnt_reg <= 24'h000000;
    end else if (init_reg) begin
      if (dv_cnt_reg == DV_LAST) begin
        init_reg <= 1'b0;
      end else begin
        dv_cnt_reg <= dv_cnt_reg + 24'h000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Summary and read data
  // ----------------------------------------------------------------
  always_comb begin
    summary_now                   = 8'h00;
    summary_now[SUM_CHAN_A_BIT]   = |CHAN_A_STATUS_REG;
    summary_now[SUM_CHAN_B_BIT]   = |CHAN_B_STATUS_REG;
    summary_now[SUM_LINK_BIT]     = OUTPUT_MISMATCH_FAULT | OSC_TRAINING_FAULT;
    // Busy bit is a live level, so it drops when programming ends.
    summary_now[SUM_MEMTHERM_BIT] = FACTORY_MEM_FAULT | USER_MEM_FAULT |
                                    USER_ARRAY_FAULT | USER_PROG_BUSY |
                                    CHAN_A_THERMAL_FAULT | CHAN_B_THERMAL_FAULT;
    summary_now[SUM_SUPPLY_BIT]   = |(supply_reg & 8'hED);
    summary_now[SUM_TEST_BIT]     = test_reg;
    summary_now[SUM_RESET_BIT]    = reset_seen_reg;
    summary_now[SUM_INIT_BIT]     = init_reg;
  end

  // Read returns the value before the clear that the same read causes.
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rd_data_reg <= RD_DATA_RST;
    end else if (rd_summary) begin
      rd_data_reg <= summary_now;
    end else if (rd_supply) begin
      rd_data_reg <= supply_reg;
    end else if (RD_STB) begin
      rd_data_reg <= RD_DATA_RST;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      summary_out_reg <= SUMMARY_RST;
      supply_out_reg  <= SUPPLY_RST;
    end else begin
      summary_out_reg <= summary_now;
      supply_out_reg  <= supply_reg;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign RD_DATA             = rd_data_reg;
  assign RESP_SUPPRESS       = suppress_reg;
  assign ERR_CODE_SEND       = err_code_reg;
  assign SUMMARY_STATUS      = summary_out_reg;
  assign SUPPLY_FAULT_STATUS = supply_out_reg;

endmodule

// *** tb/dssf_status_checker.sv ***
// Assertions on the ports of the status and supply fault block.
// Assumes the bind below attaches it to every instance of that block.
`timescale 1ns/1ps

module dssf_status_checker #(
  parameter int unsigned TICK_CYCLES       = dssf_pkg::TICK_CYCLES_DEF,
  parameter int unsigned RECOVERY_TICKS    = dssf_pkg::RECOVERY_TICKS_DEF,
  parameter int unsigned DATA_VALID_CYCLES = dssf_pkg::DATA_VALID_CYCLES_DEF
) (
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       RD_STB,
  input wire logic [7:0] RD_ADDR,
  input wire logic       STAT_TX_STB,
  input wire logic       RESP_DONE,
  input wire logic       RESP_SUPPRESS,
  input wire logic       ERR_CODE_SEND,
  input wire logic [3:0] CHAN_A_STATUS_REG,
  input wire logic [3:0] CHAN_B_STATUS_REG,
  input wire logic       TEST_ENTER,
  input wire logic       BUFFER_UNDERVOLTAGE,
  input wire logic [7:0] SUMMARY_STATUS,
  input wire logic [7:0] SUPPLY_FAULT_STATUS
);
  import dssf_pkg::*;

  // Settling time after reset, so reset-era values never feed a check other than a_err_once
  logic [2:0] age_reg;
  wire        rdy = (age_reg == 3'h7);

  always_ff @(posedge CLK) begin
    if (SYS_RST) age_reg <= 3'h0;
    else if (!rdy) age_reg <= age_reg + 3'h1;
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_chan_a_or: assert property (
    (rdy && $stable(CHAN_A_STATUS_REG))[*3] |-> SUMMARY_STATUS[7] == (|CHAN_A_STATUS_REG))
    else $error("channel a summary wrong");
  a_chan_b_or: assert property (
    (rdy && $stable(CHAN_B_STATUS_REG))[*3] |-> SUMMARY_STATUS[6] == (|CHAN_B_STATUS_REG))
    else $error("channel b summary wrong");
  a_supply_sum: assert property (
    (rdy && $stable(SUPPLY_FAULT_STATUS))[*3]
    |-> SUMMARY_STATUS[3] == (|(SUPPLY_FAULT_STATUS & 8'hFD)))
    else $error("supply summary wrong");
  a_bufuv_set: assert property (
    (rdy && BUFFER_UNDERVOLTAGE)[*5] |-> SUPPLY_FAULT_STATUS[7])
    else $error("buffer undervoltage bit not set");
  a_fault_mutes: assert property (
    (rdy && BUFFER_UNDERVOLTAGE)[*4] |-> RESP_SUPPRESS)
    else $error("response not suppressed");
  a_reset_flag_clr: assert property (
    rdy && (STAT_TX_STB || (RD_STB && RD_ADDR == SUMMARY_OFS)) |-> ##3 !SUMMARY_STATUS[1])
    else $error("reset flag not cleared");
  a_test_set: assert property (
    rdy && TEST_ENTER |-> ##2 SUMMARY_STATUS[2])
    else $error("test flag not set");
  a_err_once: assert property (
    ERR_CODE_SEND && RESP_DONE |-> ##2 !ERR_CODE_SEND)
    else $error("error code outlived its response");
endmodule

bind dssf_status dssf_status_checker #(
  .TICK_CYCLES(TICK_CYCLES), .RECOVERY_TICKS(RECOVERY_TICKS),
  .DATA_VALID_CYCLES(DATA_VALID_CYCLES)
) u_chk (
  .CLK(CLK), .SYS_RST(SYS_RST), .RD_STB(RD_STB), .RD_ADDR(RD_ADDR),
  .STAT_TX_STB(STAT_TX_STB), .RESP_DONE(RESP_DONE), .RESP_SUPPRESS(RESP_SUPPRESS),
  .ERR_CODE_SEND(ERR_CODE_SEND), .CHAN_A_STATUS_REG(CHAN_A_STATUS_REG),
  .CHAN_B_STATUS_REG(CHAN_B_STATUS_REG), .TEST_ENTER(TEST_ENTER),
  .BUFFER_UNDERVOLTAGE(BUFFER_UNDERVOLTAGE), .SUMMARY_STATUS(SUMMARY_STATUS),
  .SUPPLY_FAULT_STATUS(SUPPLY_FAULT_STATUS)
);

// *** tb/dssf_host.sv ***
// Host controller model: register reads, status sends, response done.
// Assumes the block samples on the rising edge; this drives at the falling one.
`timescale 1ns/1ps

module dssf_host (
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  output logic            rd_stb,
  output logic      [7:0] rd_addr,
  output logic            stat_tx_stb,
  output logic            resp_done
);
  initial begin
    rd_stb = 1'b0;
    rd_addr = 8'hFF;
    stat_tx_stb = 1'b0;
    resp_done = 1'b0;
  end

  // Idle address is inverted so a stale value can never look valid
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    rd_stb = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_stb = 1'b0;
    rd_addr = ~a;
    @(negedge clk);
    d = rd_data;
  endtask

  // One-cycle pulse: status send when sel is 1, response done otherwise
  task automatic strobe(input logic sel);
    @(negedge clk);
    stat_tx_stb = sel;
    resp_done = !sel;
    @(negedge clk);
    stat_tx_stb = 1'b0;
    resp_done = 1'b0;
  endtask
endmodule

// *** tb/dssf_status_tb_top.sv ***
// Self-checking bench for the status and supply fault block.
// Assumes the host model and checker are compiled before this file.
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end

module dssf_status_tb_top;
  import dssf_pkg::*;
  localparam int unsigned TICK = 4;
  localparam int unsigned RECOV = 3;
  localparam int unsigned DVALID = 10;
  logic       clk, sys_rst, t_on, t_off, pol, rd_stb, tx, done, sup, err;
  logic [2:0] proto;
  logic [3:0] ch_a, ch_b;
  logic [7:0] src, mon, c1a, c1b, c3a, c3b, rd_data, summary, supply, rd_addr, d;
  int         n_mismatch = 0;
  int         total_checks = 0;
  int         pins[7] = '{7, 6, 5, 3, 2, 1, 0};

  dssf_status #(.TICK_CYCLES(TICK), .RECOVERY_TICKS(RECOV), .DATA_VALID_CYCLES(DVALID)) uut (
    .CLK(clk), .SYS_RST(sys_rst), .RD_STB(rd_stb), .RD_ADDR(rd_addr), .RD_DATA(rd_data),
    .STAT_TX_STB(tx), .RESP_DONE(done), .RESP_SUPPRESS(sup), .ERR_CODE_SEND(err),
    .PROTOCOL_SELECT(proto), .SUPPLY_CLEAR_POLICY(pol),
    .CHAN_A_USER_CONFIG_ONE(c1a), .CHAN_B_USER_CONFIG_ONE(c1b),
    .CHAN_A_USER_CONFIG_THREE(c3a), .CHAN_B_USER_CONFIG_THREE(c3b),
    .CHAN_A_STATUS_REG(ch_a), .CHAN_B_STATUS_REG(ch_b),
    .OUTPUT_MISMATCH_FAULT(src[0]), .OSC_TRAINING_FAULT(src[1]),
    .FACTORY_MEM_FAULT(src[2]), .USER_MEM_FAULT(src[3]), .USER_ARRAY_FAULT(src[4]),
    .USER_PROG_BUSY(src[5]), .CHAN_A_THERMAL_FAULT(src[6]), .CHAN_B_THERMAL_FAULT(src[7]),
    .TEST_ENTER(t_on), .TEST_EXIT(t_off),
    .BUFFER_UNDERVOLTAGE(mon[7]), .BUS_INPUT_UNDERVOLTAGE(mon[6]),
    .BUFFER_OVERVOLTAGE(mon[5]), .ANALOG_REGULATOR_FAULT(mon[3]),
    .DIGITAL_REGULATOR_FAULT(mon[2]), .OTP_REGULATOR_FAULT(mon[1]),
    .PERIMETER_CONTINUITY_FAULT(mon[0]), .SUMMARY_STATUS(summary), .SUPPLY_FAULT_STATUS(supply)
  );

  dssf_host host (.clk(clk), .rd_data(rd_data), .rd_stb(rd_stb), .rd_addr(rd_addr),
    .stat_tx_stb(tx), .resp_done(done));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic print_verdict;
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic t_reset;
    repeat (6) @(negedge clk);
    `CHK("summary rst", SUMMARY_RST, summary)
    `CHK("supply rst", SUPPLY_RST, supply)
    `CHK("rd_data rst", RD_DATA_RST, rd_data)
    `CHK("mute rst", 2'b00, ({sup, err}))
    sys_rst = 1'b0;
  endtask

  task automatic t_init;
    wait_n(3);
    `CHK("init at reset", 1'b1, summary[SUM_INIT_BIT])
    wait_n(DVALID + 4);
    `CHK("init done", 1'b0, summary[SUM_INIT_BIT])
    c1a = c1a ^ 8'h04;
    wait_n(3);
    `CHK("init cfg one", 1'b1, summary[SUM_INIT_BIT])
    wait_n(DVALID + 4);
    c1b = c1b ^ 8'h03;
    wait_n(3);
    `CHK("init unwatched", 1'b0, summary[SUM_INIT_BIT])
    c3b = c3b ^ 8'h02;
    wait_n(3);
    `CHK("init cfg three", 1'b1, summary[SUM_INIT_BIT])
    wait_n(DVALID + 4);
  endtask

  task automatic t_summary;
    for (int i = 0; i < 4; i++) begin
      ch_a = 4'h1 << i;
      ch_b = 4'h0;
      wait_n(3);
      `CHK("chan a", 2'b10, summary[7:6])
      ch_a = 4'h0;
      ch_b = 4'h1 << i;
      wait_n(3);
      `CHK("chan b", 2'b01, summary[7:6])
    end
    for (int i = 0; i < 8; i++) begin
      src = 8'h01 << i;
      wait_n(3);
      `CHK("link memtherm", ({i < 2, i >= 2}), summary[5:4])
    end
    ch_b = 4'h0;
    src = 8'h00;
    wait_n(3);
    `CHK("all quiet", 4'h0, summary[7:4])
  endtask

  task automatic t_read_test;
    host.read(SUMMARY_OFS, d);
    `CHK("reset flag", 1'b1, d[SUM_RESET_BIT])
    wait_n(2);
    `CHK("reset flag gone", 1'b0, summary[SUM_RESET_BIT])
    host.read(8'h00, d);
    `CHK("unmapped read", 8'h00, d)
    t_on = 1'b1;
    wait_n(1);
    t_on = 1'b0;
    host.read(SUMMARY_OFS, d);
    `CHK("test read", 1'b1, d[SUM_TEST_BIT])
    wait_n(3);
    `CHK("test held", 1'b1, summary[SUM_TEST_BIT])
    t_off = 1'b1;
    wait_n(1);
    t_off = 1'b0;
    wait_n(3);
    `CHK("test off", 1'b0, summary[SUM_TEST_BIT])
  endtask

  task automatic t_supply(input logic [2:0] p, input logic pl, input int b);
    int n;
    logic [7:0] e;
    e = 8'h01 << b;
    proto = p;
    pol = pl;
    mon = e;
    wait_n(6);
    `CHK("supply bit", e, supply)
    `CHK("supply sum", e != 8'h02, summary[SUM_SUPPLY_BIT])
    `CHK("muted", 1'b1, sup)
    mon = 8'h00;
    host.read(SUPPLY_OFS, d);
    `CHK("early read", e, d)
    `CHK("no early clear", e, supply)
    n = 3;
    while (sup === 1'b1 && n < 40) begin
      wait_n(1);
      n++;
    end
    if (n >= 40) begin
      n_mismatch++;
      print_verdict();
    end
    `CHK("recovery", 1'b1, n >= (RECOV - 1) * TICK && n <= RECOV * TICK + 6)
    wait_n(2);
    if (pl || p == PROTO_PSI5_A || p == PROTO_PSI5_B) begin
      `CHK("auto clear", 9'h000, ({err, supply}))
    end else begin
      `CHK("kept", e, supply)
      `CHK("err code", p < 3'h6, err)
      host.strobe(1'b0);
      wait_n(2);
      `CHK("err once", 1'b0, err)
      if (p == PROTO_SPI_A) host.strobe(1'b1);
      else host.read(SUPPLY_OFS, d);
      wait_n(2);
      `CHK("cleared", 8'h00, supply)
    end
  endtask

  initial begin
    {sys_rst, t_on, t_off, pol, proto} = 7'h40;
    {ch_a, ch_b, src, mon} = 24'h000000;
    {c1a, c1b, c3a, c3b} = 32'h00000000;
    t_reset();
    t_init();
    t_summary();
    t_read_test();
    for (int p = 0; p < 8; p++) t_supply(p[2:0], 1'b0, pins[p % 7]);
    t_supply(PROTO_DSI3_A, 1'b1, 0);
    t_supply(PROTO_I2C_B, 1'b1, 1);
    print_verdict();
  end
endmodule
